/* File: lcm_defs.svh */
// Offsets, field positions, reset values and time steps of the meter bank.
`ifndef LCM_DEFS_SVH
`define LCM_DEFS_SVH

// Command byte layout.
`define LCM_CMD_WRITE_BIT   7
`define LCM_ADDR_W          7

// Register addresses carried in the low seven command bits.
`define LCM_ADDR_METER_CTRL 7'h09
`define LCM_ADDR_DEBOUNCE   7'h0A
`define LCM_ADDR_TX_LOW     7'h0B
`define LCM_ADDR_TX_HIGH    7'h0C
`define LCM_ADDR_RECOG_TIME 7'h0D
`define LCM_ADDR_RECOG_BRK  7'h0E
`define LCM_ADDR_END_TIME   7'h0F
`define LCM_ADDR_END_BRK    7'h10

// Level-meter control fields.
`define LCM_OVER_BIT        7
`define LCM_GAIN_BIT        6
`define LCM_RECT_BIT        5
`define LCM_THR_MSB         2
`define LCM_THR_LSB         0

// Debounce fields.
`define LCM_SUP_DB_MSB      7
`define LCM_SUP_DB_LSB      4
`define LCM_IO_DB_MSB       3
`define LCM_IO_DB_LSB       0

// Reset values.
`define LCM_RST_METER_CTRL  8'h00
`define LCM_RST_DEBOUNCE    8'h00
`define LCM_RST_RECOG_TIME  8'h13
`define LCM_RST_RECOG_BRK   8'h19
`define LCM_RST_END_TIME    8'h40
`define LCM_RST_END_BRK     8'h64
`define LCM_RST_TX          8'h00
`define LCM_RST_PORT_MODE   1'h1

// Time steps: 2000 us per debounce code over a 2500 us pin base, 16 ms and 4 ms per code.
`define LCM_SUP_DB_STEP_US  16'h07D0
`define LCM_IO_DB_BASE_US   16'h09C4
`define LCM_IO_DB_STEP_US   16'h07D0
`define LCM_RT_MS_PER_CODE  12'h010
`define LCM_BRK_MS_PER_CODE 10'h004

// Meter gain shift (times 16) and threshold step (12.5 % of full scale).
`define LCM_GAIN_SHIFT      4
`define LCM_THR_STEP_BITS   12

`endif

/* File: lcm_pkg.sv */
// Types shared by the meter and tone register bank.
package lcm_pkg;

    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } lcm_cmd_s;

    typedef struct packed {
        logic [11:0] recognition_time;
        logic [9:0]  recognition_break_time;
        logic [9:0]  end_detect_time;
        logic [7:0]  end_detect_break_time;
    } lcm_tone_ms_s;

endpackage

/* File: lcm_regs.sv */
// Per-channel level-meter, debounce, sample monitor and tone timing bank.
//
// Operation
// RQ1: Command bit 7 writes, low bits pick register.
// RQ2: Over-threshold bit read-only, zero after reset.
// RQ3: Flag high above threshold, low below.
// RQ4: Threshold code steps 12.5 percent from zero.
// RQ5: Gain-boost bit multiplies meter path by 16.
// RQ6: Rectifier bit enables rectifier, else bypassed.
// RQ7: Debounce register holds supervision and pin fields.
// RQ8: Low monitor holds low byte or whole sample.
// RQ9: High monitor holds high byte, compressed 00H.
// RQ10: Monitor registers exist only in microprocessor mode.
// RQ11: Recognition time code is milliseconds over 16.
// RQ12: Recognition break code is milliseconds over 4.
// RQ13: End detection code is milliseconds over 4.
// RQ14: End detection break code is plain milliseconds.
// RQ15: Meter source bit picks DC or AC path.
// RQ16: Flag re-evaluated on every new meter result.
`timescale 1ns/1ps
`include "lcm_defs.svh"

module lcm_regs
    import lcm_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Command-byte port
    input  lcm_cmd_s                cmd_in,
    output logic                    rd_valid,
    output logic [7:0]              rd_data,
    // Programming mode pin, high for the microprocessor port
    input  wire logic               port_mode_pin,
    // Level meter
    input  wire logic               meter_source_sel,
    input  wire logic               meter_result_valid,
    input  wire logic signed [15:0] meter_dc_result,
    input  wire logic signed [15:0] meter_ac_result,
    output logic                    over_threshold_flag,
    output logic signed [15:0]      meter_value,
    output logic                    meter_gain_boost,
    output logic                    meter_rectifier_on,
    output logic [2:0]              meter_threshold_sel,
    // Transmit sample monitor
    input  wire logic               tx_sample_valid,
    input  wire logic               tx_linear,
    input  wire logic [15:0]        tx_sample,
    // Debounce settings
    output logic [3:0]              supervision_debounce_sel,
    output logic [3:0]              pin_input_debounce_sel,
    output logic [15:0]             supervision_debounce_us,
    output logic [15:0]             pin_input_debounce_us,
    // Tone detector timing
    output lcm_tone_ms_s            tone_detector_times
);

    // Reset release synchroniser.
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'h0;
            rst_s2_q <= 1'h0;
        end else begin
            rst_s1_q <= 1'h1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rst_sync_n = rst_s2_q;

    // Mode pin filter: three stages, a change counts once the last two
    // agree, so a single metastable sample cannot flip the mode.
    logic mode_s1_q;
    logic mode_s2_q;
    logic mode_s3_q;
    logic port_mode_q;
    logic port_mode_d;

    always_comb begin
        port_mode_d = port_mode_q;
        if (mode_s2_q == mode_s3_q) begin
            port_mode_d = mode_s3_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_s1_q   <= `LCM_RST_PORT_MODE;
            mode_s2_q   <= `LCM_RST_PORT_MODE;
            mode_s3_q   <= `LCM_RST_PORT_MODE;
            port_mode_q <= `LCM_RST_PORT_MODE;
        end else begin
            mode_s1_q   <= port_mode_pin;
            mode_s2_q   <= mode_s1_q;
            mode_s3_q   <= mode_s2_q;
            port_mode_q <= port_mode_d;
        end
    end

    // Command decode and host-visible registers.
    logic [7:0]            meter_ctrl_q;
    logic [7:0]            meter_ctrl_d;
    logic [7:0]            debounce_q;
    logic [7:0]            debounce_d;
    logic [7:0]            recog_time_code_q;
    logic [7:0]            recog_time_code_d;
    logic [7:0]            recog_break_code_q;
    logic [7:0]            recog_break_code_d;
    logic [7:0]            end_time_code_q;
    logic [7:0]            end_time_code_d;
    logic [7:0]            end_break_code_q;
    logic [7:0]            end_break_code_d;
    logic                  rd_valid_q;
    logic                  rd_valid_d;
    logic [7:0]            rd_data_q;
    logic [7:0]            rd_data_d;
    logic [7:0]            tx_low_q;
    logic [7:0]            tx_high_q;
    logic                  over_q;
    logic [`LCM_ADDR_W-1:0] addr;
    logic                  is_write;

    assign addr     = cmd_in.cmd[`LCM_ADDR_W-1:0];
    assign is_write = cmd_in.cmd[`LCM_CMD_WRITE_BIT];

    always_comb begin
        meter_ctrl_d       = meter_ctrl_q;
        debounce_d         = debounce_q;
        recog_time_code_d  = recog_time_code_q;
        recog_break_code_d = recog_break_code_q;
        end_time_code_d    = end_time_code_q;
        end_break_code_d   = end_break_code_q;
        rd_valid_d         = 1'h0;
        rd_data_d          = rd_data_q;
        if (cmd_in.valid && is_write) begin // RQ1
            case (addr)
                `LCM_ADDR_METER_CTRL: begin
                    // Flag and reserved bits are not stored.
                    meter_ctrl_d = 8'h00; // RQ2
                    meter_ctrl_d[`LCM_GAIN_BIT] =
                        cmd_in.wdata[`LCM_GAIN_BIT]; // RQ5
                    meter_ctrl_d[`LCM_RECT_BIT] =
                        cmd_in.wdata[`LCM_RECT_BIT]; // RQ6
                    meter_ctrl_d[`LCM_THR_MSB:`LCM_THR_LSB] =
                        cmd_in.wdata[`LCM_THR_MSB:`LCM_THR_LSB]; // RQ4
                end
                `LCM_ADDR_DEBOUNCE:   debounce_d = cmd_in.wdata; // RQ7
                `LCM_ADDR_RECOG_TIME: begin
                    recog_time_code_d = cmd_in.wdata; // RQ11
                end
                `LCM_ADDR_RECOG_BRK: begin
                    recog_break_code_d = cmd_in.wdata; // RQ12
                end
                `LCM_ADDR_END_TIME: begin
                    end_time_code_d = cmd_in.wdata; // RQ13
                end
                `LCM_ADDR_END_BRK: begin
                    end_break_code_d = cmd_in.wdata; // RQ14
                end
                default: begin
                    // Monitor and unmapped addresses ignore writes.
                    rd_data_d = rd_data_q;
                end
            endcase
        end else if (cmd_in.valid) begin // RQ1
            rd_valid_d = 1'h1;
            case (addr)
                `LCM_ADDR_METER_CTRL: begin
                    rd_data_d = meter_ctrl_q;
                    rd_data_d[`LCM_OVER_BIT] = over_q; // RQ2
                end
                `LCM_ADDR_DEBOUNCE:   rd_data_d = debounce_q;
                `LCM_ADDR_TX_LOW: begin
                    rd_data_d = port_mode_q ? tx_low_q : 8'h00; // RQ10
                end
                `LCM_ADDR_TX_HIGH: begin
                    rd_data_d = port_mode_q ? tx_high_q : 8'h00; // RQ10
                end
                `LCM_ADDR_RECOG_TIME: rd_data_d = recog_time_code_q;
                `LCM_ADDR_RECOG_BRK:  rd_data_d = recog_break_code_q;
                `LCM_ADDR_END_TIME:   rd_data_d = end_time_code_q;
                `LCM_ADDR_END_BRK:    rd_data_d = end_break_code_q;
                default:              rd_data_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meter_ctrl_q       <= `LCM_RST_METER_CTRL;
            debounce_q         <= `LCM_RST_DEBOUNCE;
            recog_time_code_q  <= `LCM_RST_RECOG_TIME;
            recog_break_code_q <= `LCM_RST_RECOG_BRK;
            end_time_code_q    <= `LCM_RST_END_TIME;
            end_break_code_q   <= `LCM_RST_END_BRK;
            rd_valid_q         <= 1'h0;
            rd_data_q          <= 8'h00;
        end else begin
            meter_ctrl_q       <= meter_ctrl_d;
            debounce_q         <= debounce_d;
            recog_time_code_q  <= recog_time_code_d;
            recog_break_code_q <= recog_break_code_d;
            end_time_code_q    <= end_time_code_d;
            end_break_code_q   <= end_break_code_d;
            rd_valid_q         <= rd_valid_d;
            rd_data_q          <= rd_data_d;
        end
    end

    // Level-meter path: source, gain, rectifier and threshold compare.
    logic signed [15:0] meter_src;
    logic signed [19:0] meter_wide;
    logic signed [15:0] meter_gained;
    logic [16:0]        meter_mag;
    logic [14:0]        meter_thr;
    logic signed [15:0] meter_value_q;
    logic signed [15:0] meter_value_d;
    logic               over_d;

    always_comb begin
        meter_src = meter_source_sel ? meter_ac_result
                                     : meter_dc_result; // RQ15
        meter_wide = {{4{meter_src[15]}}, meter_src} <<< `LCM_GAIN_SHIFT;
        // Boosted values saturate rather than wrap, so a loud signal can
        // never fold back below the threshold.
        meter_gained = meter_src;
        if (meter_ctrl_q[`LCM_GAIN_BIT]) begin // RQ5
            if (meter_wide[19:15] == 5'h00 || meter_wide[19:15] == 5'h1F) begin
                meter_gained = meter_wide[15:0];
            end else if (meter_wide[19]) begin
                meter_gained = 16'sh8000;
            end else begin
                meter_gained = 16'sh7FFF;
            end
        end
        meter_mag = meter_gained[15] ? 17'(-{meter_gained[15], meter_gained})
                                     : {1'h0, meter_gained};
        meter_thr = {meter_ctrl_q[`LCM_THR_MSB:`LCM_THR_LSB],
                     {`LCM_THR_STEP_BITS{1'h0}}}; // RQ4
        meter_value_d = meter_value_q;
        over_d        = over_q;
        if (meter_result_valid) begin // RQ16
            over_d = meter_mag > {2'h0, meter_thr}; // RQ3
            if (meter_ctrl_q[`LCM_RECT_BIT]) begin // RQ6
                // A magnitude of 8000H cannot be shown signed, so it clips.
                meter_value_d = (meter_mag[16:15] != 2'h0) ? 16'sh7FFF
                                              : meter_mag[15:0];
            end else begin
                meter_value_d = meter_gained;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meter_value_q <= 16'sh0000;
            over_q        <= 1'h0; // RQ2
        end else begin
            meter_value_q <= meter_value_d;
            over_q        <= over_d;
        end
    end

    // Transmit sample monitor, frozen outside microprocessor mode.
    logic [7:0] tx_low_d;
    logic [7:0] tx_high_d;

    always_comb begin
        tx_low_d  = tx_low_q;
        tx_high_d = tx_high_q;
        if (tx_sample_valid && port_mode_q) begin // RQ10
            tx_low_d  = tx_sample[7:0]; // RQ8
            tx_high_d = tx_linear ? tx_sample[15:8] : 8'h00; // RQ9
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_low_q  <= `LCM_RST_TX;
            tx_high_q <= `LCM_RST_TX;
        end else begin
            tx_low_q  <= tx_low_d;
            tx_high_q <= tx_high_d;
        end
    end

    // Decoded times for the debounce filters and tone detector.
    logic [15:0]  sup_us_q;
    logic [15:0]  sup_us_d;
    logic [15:0]  io_us_q;
    logic [15:0]  io_us_d;
    lcm_tone_ms_s tone_q;
    lcm_tone_ms_s tone_d;

    always_comb begin
        sup_us_d = ({12'h000, debounce_q[`LCM_SUP_DB_MSB:`LCM_SUP_DB_LSB]}
                    + 16'h0001) * `LCM_SUP_DB_STEP_US; // RQ7
        io_us_d  = `LCM_IO_DB_BASE_US
                   + {12'h000, debounce_q[`LCM_IO_DB_MSB:`LCM_IO_DB_LSB]}
                   * `LCM_IO_DB_STEP_US; // RQ7
        tone_d.recognition_time = {4'h0, recog_time_code_q}
                                  * `LCM_RT_MS_PER_CODE; // RQ11
        tone_d.recognition_break_time = {2'h0, recog_break_code_q}
                                        * `LCM_BRK_MS_PER_CODE; // RQ12
        tone_d.end_detect_time = {2'h0, end_time_code_q}
                                 * `LCM_BRK_MS_PER_CODE; // RQ13
        tone_d.end_detect_break_time = end_break_code_q; // RQ14
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sup_us_q <= 16'h0000;
            io_us_q  <= 16'h0000;
            tone_q   <= '0;
        end else begin
            sup_us_q <= sup_us_d;
            io_us_q  <= io_us_d;
            tone_q   <= tone_d;
        end
    end

    // Outputs.
    assign rd_valid                 = rd_valid_q;
    assign rd_data                  = rd_data_q;
    assign over_threshold_flag      = over_q;
    assign meter_value              = meter_value_q;
    assign meter_gain_boost         = meter_ctrl_q[`LCM_GAIN_BIT];
    assign meter_rectifier_on       = meter_ctrl_q[`LCM_RECT_BIT];
    assign meter_threshold_sel      =
        meter_ctrl_q[`LCM_THR_MSB:`LCM_THR_LSB];
    assign supervision_debounce_sel =
        debounce_q[`LCM_SUP_DB_MSB:`LCM_SUP_DB_LSB];
    assign pin_input_debounce_sel   =
        debounce_q[`LCM_IO_DB_MSB:`LCM_IO_DB_LSB];
    assign supervision_debounce_us  = sup_us_q;
    assign pin_input_debounce_us    = io_us_q;
    assign tone_detector_times      = tone_q;

endmodule

/* File: lcm_host_model.sv */
// Host processor model driving the command-byte port.
`timescale 1ns/1ps
module lcm_host_model
    import lcm_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Command port
    output lcm_cmd_s        cmd_in,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    initial cmd_in = '0;

    // Released data is inverted so a stale byte can never look valid.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cmd_in <= {1'b1, 1'b1, a, d};
        @(posedge sys_clk);
        cmd_in <= {1'b0, 8'h00, ~d};
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_in <= {1'b1, 1'b0, a, 8'h00};
        @(posedge sys_clk);
        cmd_in <= {1'b0, 8'h00, 8'hFF};
        @(negedge sys_clk);
        while (rd_valid !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask
endmodule

/* File: lcm_regs_sva.sv */
// Port checks for the meter and tone register bank.
`timescale 1ns/1ps
module lcm_regs_sva
    import lcm_pkg::*;
(
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Command port
    input lcm_cmd_s                cmd_in,
    input wire logic               rd_valid,
    // Level meter
    input wire logic               meter_source_sel,
    input wire logic               meter_result_valid,
    input wire logic signed [15:0] meter_dc_result,
    input wire logic signed [15:0] meter_ac_result,
    input wire logic               over_threshold_flag,
    input wire logic signed [15:0] meter_value,
    input wire logic               meter_gain_boost,
    input wire logic               meter_rectifier_on,
    input wire logic [2:0]         meter_threshold_sel,
    // Debounce
    input wire logic [3:0]         supervision_debounce_sel,
    input wire logic [3:0]         pin_input_debounce_sel,
    input wire logic [15:0]        supervision_debounce_us,
    input wire logic [15:0]        pin_input_debounce_us
);
    // The internal reset lingers two edges, so checks wait three.
    logic [1:0]  up_q, up_d;
    logic        rdy, over_exp;
    logic [16:0] mag;
    logic [15:0] sup_exp, io_exp;

    always_comb begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
        rdy = (up_q == 2'h3);
        mag = meter_dc_result[15] ? ~{1'b1, meter_dc_result} + 17'h1
                                  : {1'b0, meter_dc_result};
        over_exp = mag > {2'h0, meter_threshold_sel, 12'h000};
        sup_exp = ({12'h000, supervision_debounce_sel} + 16'h0001) * 16'h07D0;
        io_exp = 16'h09C4 + {12'h000, pin_input_debounce_sel} * 16'h07D0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 2'h0;
        end else begin
            up_q <= up_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_rd_answer;
        rdy |=> rd_valid == ($past(cmd_in.valid) && !$past(cmd_in.cmd[7]));
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe wrong");

    property p_flag_ro;
        rdy && cmd_in.valid && cmd_in.cmd == 8'h89 && !meter_result_valid
            |=> $stable(over_threshold_flag);
    endproperty
    a_flag_ro: assert property (p_flag_ro)
        else $error("flag moved on write");

    property p_flag;
        rdy && meter_result_valid && !meter_source_sel && !meter_gain_boost
            |=> over_threshold_flag == $past(over_exp);
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag wrong");

    property p_gain;
        rdy && meter_result_valid && !meter_source_sel && meter_gain_boost
            && !meter_rectifier_on && meter_dc_result[15:11] == 5'h00
            |=> meter_value == {$past(meter_dc_result[11:0]), 4'h0};
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain wrong");

    property p_rect;
        rdy && meter_result_valid && !meter_source_sel && !meter_gain_boost
            && meter_rectifier_on && meter_dc_result[15]
            && meter_dc_result != 16'h8000
            |=> meter_value == -$past(meter_dc_result);
    endproperty
    a_rect: assert property (p_rect)
        else $error("rectifier wrong");

    property p_src;
        rdy && meter_result_valid && meter_source_sel && !meter_gain_boost
            && !meter_rectifier_on |=> meter_value == $past(meter_ac_result);
    endproperty
    a_src: assert property (p_src)
        else $error("source wrong");

    property p_sup_db;
        rdy && $stable(supervision_debounce_sel) ##1
            $stable(supervision_debounce_sel)
            |-> supervision_debounce_us == sup_exp;
    endproperty
    a_sup_db: assert property (p_sup_db)
        else $error("supervision time wrong");

    property p_io_db;
        rdy && $stable(pin_input_debounce_sel) ##1
            $stable(pin_input_debounce_sel)
            |-> pin_input_debounce_us == io_exp;
    endproperty
    a_io_db: assert property (p_io_db)
        else $error("pin time wrong");
endmodule

bind lcm_regs lcm_regs_sva chk_u (.sys_clk, .rst_n, .cmd_in, .rd_valid,
    .meter_source_sel, .meter_result_valid, .meter_dc_result,
    .meter_ac_result, .over_threshold_flag, .meter_value, .meter_gain_boost,
    .meter_rectifier_on, .meter_threshold_sel, .supervision_debounce_sel,
    .pin_input_debounce_sel, .supervision_debounce_us,
    .pin_input_debounce_us);

/* File: lcm_regs_tb.sv */
// Self-checking bench for the meter and tone register bank.
`timescale 1ns/1ps
module lcm_regs_tb
    import lcm_pkg::*;
;
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    lcm_cmd_s           cmd_in;
    logic               rd_valid, port_mode_pin, meter_source_sel;
    logic               meter_result_valid, over_threshold_flag;
    logic               tx_sample_valid, tx_linear;
    logic               meter_gain_boost, meter_rectifier_on;
    logic [7:0]         rd_data;
    logic [2:0]         meter_threshold_sel;
    logic signed [15:0] meter_dc_result, meter_ac_result, meter_value;
    logic [15:0]        tx_sample, sup_us, io_us;
    logic [3:0]         sup_sel, io_sel;
    lcm_tone_ms_s       tone;
    int                 err_total = 0;
    int                 num_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    lcm_regs dut_u (.sys_clk, .rst_n, .cmd_in, .rd_valid, .rd_data,
        .port_mode_pin, .meter_source_sel, .meter_result_valid,
        .meter_dc_result, .meter_ac_result, .over_threshold_flag,
        .meter_value, .meter_gain_boost, .meter_rectifier_on,
        .meter_threshold_sel, .tx_sample_valid, .tx_linear, .tx_sample,
        .supervision_debounce_sel(sup_sel), .pin_input_debounce_sel(io_sel),
        .supervision_debounce_us(sup_us), .pin_input_debounce_us(io_us),
        .tone_detector_times(tone));

    lcm_host_model host_u (.sys_clk, .cmd_in, .rd_valid, .rd_data);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    task automatic mtr(input logic s, input logic [15:0] dc, ac);
        @(posedge sys_clk);
        meter_source_sel <= s;
        meter_dc_result <= dc;
        meter_ac_result <= ac;
        meter_result_valid <= 1'b1;
        @(posedge sys_clk);
        meter_result_valid <= 1'b0;
        meter_dc_result <= ~dc;
        @(negedge sys_clk);
    endtask

    task automatic txs(input logic lin, input logic [15:0] s);
        @(posedge sys_clk);
        tx_linear <= lin;
        tx_sample <= s;
        tx_sample_valid <= 1'b1;
        @(posedge sys_clk);
        tx_sample_valid <= 1'b0;
        tx_sample <= ~s;
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        conclude();
    end

    initial begin
        int i;
        port_mode_pin = 1'b1;
        meter_source_sel = 1'b0;
        meter_result_valid = 1'b0;
        meter_dc_result = 16'h0000;
        meter_ac_result = 16'h0000;
        tx_sample_valid = 1'b0;
        tx_linear = 1'b1;
        tx_sample = 16'h0000;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rchk(7'h09, 8'h00);
        rchk(7'h0A, 8'h00);
        rchk(7'h0D, 8'h13);
        rchk(7'h0E, 8'h19);
        rchk(7'h0F, 8'h40);
        rchk(7'h10, 8'h64);
        chk({4'h0, tone.recognition_time}, 16'h0130);
        chk({6'h00, tone.recognition_break_time}, 16'h0064);
        chk({6'h00, tone.end_detect_time}, 16'h0100);
        chk({8'h00, tone.end_detect_break_time}, 16'h0064);
        $display("Test reset done");
        for (i = 0; i < 4; i++) host_u.wr(7'h0D + i[6:0], 8'hFA);
        for (i = 0; i < 4; i++) rchk(7'h0D + i[6:0], 8'hFA);
        chk({4'h0, tone.recognition_time}, 16'h0FA0);
        chk({6'h00, tone.recognition_break_time}, 16'h03E8);
        chk({6'h00, tone.end_detect_time}, 16'h03E8);
        chk({8'h00, tone.end_detect_break_time}, 16'h00FA);
        host_u.wr(7'h0A, 8'hEE);
        rchk(7'h0A, 8'hEE);
        chk(sup_us, 16'h7530);
        chk(io_us, 16'h7724);
        chk({8'h00, sup_sel, io_sel}, 16'h00EE);
        rchk(7'h20, 8'h00);
        $display("Test registers done");
        // Reserved bits are written high to show they do not stick.
        for (i = 0; i < 8; i++) begin
            host_u.wr(7'h09, {5'h03, i[2:0]});
            rchk(7'h09, {5'h00, i[2:0]});
            chk({13'h0, meter_threshold_sel}, {13'h0, i[2:0]});
            mtr(1'b0, ~{1'b0, i[2:0], 12'h000}, 16'h7FFF);
            chk({15'h0, over_threshold_flag}, 16'h0001);
            mtr(1'b0, {1'b0, i[2:0], 12'h000}, 16'h7FFF);
            chk({15'h0, over_threshold_flag}, 16'h0000);
        end
        mtr(1'b0, 16'h7FFF, 16'h0000);
        rchk(7'h09, 8'h87);
        host_u.wr(7'h09, 8'h07);
        rchk(7'h09, 8'h87);
        host_u.wr(7'h09, 8'h40);
        mtr(1'b0, 16'h0100, 16'h0000);
        chk(meter_value, 16'h1000);
        chk({14'h0, meter_gain_boost, meter_rectifier_on}, 16'h0002);
        mtr(1'b0, 16'h1000, 16'h0000);
        chk(meter_value, 16'h7FFF);
        host_u.wr(7'h09, 8'h20);
        mtr(1'b0, 16'hF000, 16'h0000);
        chk(meter_value, 16'h1000);
        chk({14'h0, meter_gain_boost, meter_rectifier_on}, 16'h0001);
        mtr(1'b0, 16'h8000, 16'h0000);
        chk(meter_value, 16'h7FFF);
        host_u.wr(7'h09, 8'h00);
        mtr(1'b0, 16'hF000, 16'h0000);
        chk(meter_value, 16'hF000);
        mtr(1'b1, 16'h0000, 16'h0123);
        chk(meter_value, 16'h0123);
        chk({15'h0, over_threshold_flag}, 16'h0001);
        $display("Test meter done");
        txs(1'b1, 16'hABCD);
        rchk(7'h0B, 8'hCD);
        rchk(7'h0C, 8'hAB);
        txs(1'b0, 16'h1234);
        rchk(7'h0B, 8'h34);
        rchk(7'h0C, 8'h00);
        host_u.wr(7'h0B, 8'h55);
        rchk(7'h0B, 8'h34);
        @(posedge sys_clk);
        port_mode_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rchk(7'h0B, 8'h00);
        txs(1'b1, 16'h5678);
        port_mode_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rchk(7'h0B, 8'h34);
        $display("Test monitor done");
        conclude();
    end
endmodule
